//--- design/vri_cfg.svh
`ifndef VRI_CFG_SVH
`define VRI_CFG_SVH

// Register byte offsets; VRI_OFS_REQ_PAGE is the page number matched against paddr[11:7]
`define VRI_OFS_THR0 12'h000
`define VRI_OFS_THR1 12'h004
`define VRI_OFS_VEC0 12'h100
`define VRI_OFS_VEC1 12'h104
`define VRI_OFS_PEND 12'h200
`define VRI_OFS_FEAT 12'h300
`define VRI_OFS_REQ_PAGE 5'h08
`define VRI_OFS_STAT 12'h500
`define VRI_OFS_CLR 12'h504
`define VRI_OFS_EN 12'h508

// Field values and reset values
`define VRI_FEAT_TGT 6'h01
`define VRI_FEAT_PRIO 8'h0f
`define VRI_FEAT_NREQ 8'h1f
`define VRI_ACT_LOW_MASK 31'h0000_000f
`define VRI_THR_RST 4'h0
`define VRI_PRIO_RST 4'h0
`define VRI_BASE_RST 21'h00_0000
`define VRI_PRIO_MASKED 4'h0
`define VRI_IDX_NONE 5'h00
`define VRI_NUM_REQ 31

`endif

//--- design/vri_pkg.sv
package vri_pkg;

    typedef struct packed {
        logic [20:0] base;
        logic [2:0] rsv;
        logic [4:0] idx;
        logic [2:0] nul;
    } vri_vec_type;

    typedef struct packed {
        logic [9:0] rsv;
        logic [5:0] tgt;
        logic [7:0] prio;
        logic [7:0] nreq;
    } vri_feat_type;

    typedef struct packed {
        logic [30:0] bits;
        logic zero;
    } vri_line_word_type;

endpackage

//--- design/vri_top.sv
`timescale 1ns/1ns
`include "vri_cfg.svh"
module vri_top #(
    parameter logic [30:0] ACT_LOW = `VRI_ACT_LOW_MASK
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:1] irq_req,
    output logic [1:0] irq_target,
    output logic irq
);

    logic [31:1] pend_r;
    logic [31:1] pend_d_r;
    logic [31:1] stat_r;
    logic [31:1] en_r;
    logic [3:0] thr_r [0:1];
    logic [20:0] base_r [0:1];
    logic [3:0] prio_r [1:31];
    logic [4:0] best_idx [0:1];
    logic [1:0] irq_target_r;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] rd_val;
    logic hit;
    logic setup;
    logic wr_acc;
    logic [4:0] req_sel;
    vri_pkg::vri_vec_type vec_w [0:1];
    vri_pkg::vri_feat_type feat_w;
    vri_pkg::vri_line_word_type pend_w;
    logic [31:1] qual_w [0:1];
    logic [3:0] top_prio_w [0:1];
    logic [1:0] lower_tie_w;

    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready_r & pwrite;
    assign req_sel = paddr[6:2];

    // Request capture with per-line polarity
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pend_r <= '0;
            pend_d_r <= '0;
        end else begin
            pend_r <= irq_req ^ ACT_LOW;
            pend_d_r <= pend_r;
        end
    end

    // Highest priority qualifying line per target
    always_comb begin
        logic [3:0] bp;
        logic [4:0] bi;
        bp = `VRI_PRIO_MASKED;
        bi = `VRI_IDX_NONE;
        for (int t = 0; t < 2; t++) begin
            bp = `VRI_PRIO_MASKED;
            bi = `VRI_IDX_NONE;
            for (int n = `VRI_NUM_REQ; n >= 1; n--) begin
                if (pend_r[n] && prio_r[n] != `VRI_PRIO_MASKED
                        && prio_r[n] > thr_r[t]
                        && prio_r[n] >= bp) begin
                    bp = prio_r[n];
                    bi = 5'(n);
                end
            end
            best_idx[t] = bi;
        end
    end

    // Vector, features and pending words
    always_comb begin
        for (int t = 0; t < 2; t++) begin
            vec_w[t].base = base_r[t];
            vec_w[t].rsv = 3'h0;
            vec_w[t].idx = best_idx[t];
            vec_w[t].nul = 3'h0;
        end
        feat_w.rsv = 10'h000;
        feat_w.tgt = `VRI_FEAT_TGT;
        feat_w.prio = `VRI_FEAT_PRIO;
        feat_w.nreq = `VRI_FEAT_NREQ;
        pend_w.bits = pend_r;
        pend_w.zero = 1'b0;
    end

    // Read decode
    always_comb begin
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == `VRI_OFS_THR0) begin
            rd_val = {28'h000_0000, thr_r[0]};
        end else if (paddr == `VRI_OFS_THR1) begin
            rd_val = {28'h000_0000, thr_r[1]};
        end else if (paddr == `VRI_OFS_VEC0) begin
            rd_val = vec_w[0];
        end else if (paddr == `VRI_OFS_VEC1) begin
            rd_val = vec_w[1];
        end else if (paddr == `VRI_OFS_PEND) begin
            rd_val = pend_w;
        end else if (paddr == `VRI_OFS_FEAT) begin
            rd_val = feat_w;
        end else if (paddr[11:7] == `VRI_OFS_REQ_PAGE && paddr[1:0] == 2'h0 && req_sel != 5'h00) begin
            rd_val = {pend_r[req_sel], 27'h000_0000, prio_r[req_sel]};
        end else if (paddr == `VRI_OFS_STAT) begin
            rd_val = {stat_r, 1'b0};
        end else if (paddr == `VRI_OFS_CLR) begin
            rd_val = 32'h0000_0000;
        end else if (paddr == `VRI_OFS_EN) begin
            rd_val = {en_r, 1'b0};
        end else begin
            hit = 1'b0;
        end
    end

    // Bus answer: one access cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata_r <= rd_val;
            end else if (setup) begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // Threshold registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            thr_r[0] <= `VRI_THR_RST;
            thr_r[1] <= `VRI_THR_RST;
        end else if (wr_acc && paddr == `VRI_OFS_THR0) begin
            thr_r[0] <= pwdata[3:0];
        end else if (wr_acc && paddr == `VRI_OFS_THR1) begin
            thr_r[1] <= pwdata[3:0];
        end
    end

    // Table base registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            base_r[0] <= `VRI_BASE_RST;
            base_r[1] <= `VRI_BASE_RST;
        end else if (wr_acc && paddr == `VRI_OFS_VEC0) begin
            base_r[0] <= pwdata[31:11];
        end else if (wr_acc && paddr == `VRI_OFS_VEC1) begin
            base_r[1] <= pwdata[31:11];
        end
    end

    // Per-line priority registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int n = 1; n <= `VRI_NUM_REQ; n++) begin
                prio_r[n] <= `VRI_PRIO_RST;
            end
        end else if (wr_acc && paddr[11:7] == `VRI_OFS_REQ_PAGE && paddr[1:0] == 2'h0
                && req_sel != 5'h00) begin
            prio_r[req_sel] <= pwdata[3:0];
        end
    end

    // Event status, enable and summary line
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stat_r <= '0;
            en_r <= '0;
            irq_r <= 1'b0;
        end else begin
            if (wr_acc && paddr == `VRI_OFS_CLR) begin
                stat_r <= (stat_r & ~pwdata[31:1]) | (pend_r & ~pend_d_r);
            end else begin
                stat_r <= stat_r | (pend_r & ~pend_d_r);
            end
            if (wr_acc && paddr == `VRI_OFS_EN) begin
                en_r <= pwdata[31:1];
            end
            irq_r <= |(stat_r & en_r);
        end
    end

    // Target request outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_target_r <= 2'b00;
        end else begin
            irq_target_r[0] <= best_idx[0] != `VRI_IDX_NONE;
            irq_target_r[1] <= best_idx[1] != `VRI_IDX_NONE;
        end
    end

    // Reference view of qualifying lines, read only by the checks
    always_comb begin
        for (int t = 0; t < 2; t++) begin
            qual_w[t] = '0;
            top_prio_w[t] = `VRI_PRIO_MASKED;
            lower_tie_w[t] = 1'b0;
            for (int n = 1; n <= `VRI_NUM_REQ; n++) begin
                qual_w[t][n] = pend_r[n] && prio_r[n] != `VRI_PRIO_MASKED
                    && prio_r[n] > thr_r[t];
                if (qual_w[t][n] && prio_r[n] > top_prio_w[t]) begin
                    top_prio_w[t] = prio_r[n];
                end
            end
            for (int n = 1; n <= `VRI_NUM_REQ; n++) begin
                if (n < best_idx[t] && qual_w[t][n] && prio_r[n] == top_prio_w[t]) begin
                    lower_tie_w[t] = 1'b1;
                end
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq_target = irq_target_r;
    assign irq = irq_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_rd_setup(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    sequence s_wr_done(logic [11:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence

    chk_vec_index: assert property (
        s_rd_setup(`VRI_OFS_VEC0) |=> pready && prdata[7:3] == $past(best_idx[0], 1))
        else $error("vector index not the resolved line");

    chk_idx_none: assert property (
        qual_w[0] == '0 |-> best_idx[0] == `VRI_IDX_NONE)
        else $error("target 0 index nonzero with nothing qualifying");

    chk_base_write: assert property (
        s_wr_done(`VRI_OFS_VEC1) |=> base_r[1] == $past(pwdata[31:11], 1))
        else $error("table base not written");

    chk_vec_zeros: assert property (
        s_rd_setup(`VRI_OFS_VEC1) |=> prdata[10:8] == 3'h0 && prdata[2:0] == 3'h0)
        else $error("vector reserved bits not zero");

    chk_pend_mirror: assert property (
        s_rd_setup(`VRI_OFS_PEND) |=> prdata == {$past(pend_r, 1), 1'b0})
        else $error("pending summary mismatch");

    chk_feat_value: assert property (
        s_rd_setup(`VRI_OFS_FEAT) |=> prdata == 32'h0001_0f1f)
        else $error("features word wrong");

    chk_line_polarity: assert property (
        ##1 pend_r[4:1] == ~$past(irq_req[4:1], 1) && pend_r[7:5] == $past(irq_req[7:5], 1))
        else $error("request polarity wrong");

    chk_prio_qualify: assert property (
        best_idx[0] != 5'h00 |-> prio_r[best_idx[0]] != 4'h0 && prio_r[best_idx[0]] > thr_r[0]
            ##1 irq_target[0])
        else $error("target 0 selection not qualified");

    chk_tie_lowest: assert property (
        best_idx[1] > 5'h01 |-> !(pend_r[1] && prio_r[1] > thr_r[1]
            && prio_r[1] >= prio_r[best_idx[1]]))
        else $error("tie not resolved to lowest line");

    chk_idx_none1: assert property (
        qual_w[1] == '0 |-> best_idx[1] == `VRI_IDX_NONE)
        else $error("target 1 index nonzero with nothing qualifying");

    chk_idx_valid0: assert property (
        qual_w[0] != '0 |-> best_idx[0] != `VRI_IDX_NONE && qual_w[0][best_idx[0]])
        else $error("target 0 index not a qualifying line");

    chk_idx_valid1: assert property (
        qual_w[1] != '0 |-> best_idx[1] != `VRI_IDX_NONE && qual_w[1][best_idx[1]])
        else $error("target 1 index not a qualifying line");

    chk_idx_top0: assert property (
        best_idx[0] != `VRI_IDX_NONE |-> prio_r[best_idx[0]] == top_prio_w[0])
        else $error("target 0 index not the highest priority");

    chk_idx_top1: assert property (
        best_idx[1] != `VRI_IDX_NONE |-> prio_r[best_idx[1]] == top_prio_w[1])
        else $error("target 1 index not the highest priority");

    chk_tie_first0: assert property (
        !lower_tie_w[0])
        else $error("target 0 tie not given to lowest line");

    chk_tie_first1: assert property (
        !lower_tie_w[1])
        else $error("target 1 tie not given to lowest line");

    chk_vec1_index: assert property (
        s_rd_setup(`VRI_OFS_VEC1) |=> pready && prdata[7:3] == $past(best_idx[1], 1))
        else $error("target 1 vector index not the resolved line");

    chk_vec_base: assert property (
        s_rd_setup(`VRI_OFS_VEC0) |=> prdata[31:11] == $past(base_r[0], 1))
        else $error("target 0 table base read wrong");

    chk_base_read1: assert property (
        s_rd_setup(`VRI_OFS_VEC1) |=> prdata[31:11] == $past(base_r[1], 1))
        else $error("target 1 table base read wrong");

    chk_base_write0: assert property (
        s_wr_done(`VRI_OFS_VEC0) |=> base_r[0] == $past(pwdata[31:11], 1))
        else $error("target 0 table base not written");

    chk_thr_write: assert property (
        s_wr_done(`VRI_OFS_THR0) |=> thr_r[0] == $past(pwdata[3:0], 1))
        else $error("target 0 threshold not written");

    chk_thr_write1: assert property (
        s_wr_done(`VRI_OFS_THR1) |=> thr_r[1] == $past(pwdata[3:0], 1))
        else $error("target 1 threshold not written");

    chk_target_level: assert property (
        ##1 irq_target == {$past(best_idx[1], 1) != 5'h00, $past(best_idx[0], 1) != 5'h00})
        else $error("target request outputs do not follow selection");

    chk_vec_zeros0: assert property (
        s_rd_setup(`VRI_OFS_VEC0) |=> prdata[10:8] == 3'h0 && prdata[2:0] == 3'h0)
        else $error("target 0 vector reserved bits not zero");

    chk_prio_qualify1: assert property (
        best_idx[1] != 5'h00 |-> prio_r[best_idx[1]] != 4'h0 && prio_r[best_idx[1]] > thr_r[1])
        else $error("target 1 selection not qualified");

    chk_pend_bit0: assert property (
        s_rd_setup(`VRI_OFS_PEND) |=> pready && prdata[0] == 1'b0)
        else $error("pending summary bit 0 not zero");

endmodule // vri_top

//--- tb/vri_periph_model.sv
`timescale 1ns/1ns
`include "vri_cfg.svh"
module vri_periph_model (
    input wire logic [31:1] line_active,
    output logic [31:1] irq_req
);
    // Timer lines pull low when active, the rest drive high
    assign irq_req = line_active ^ `VRI_ACT_LOW_MASK;
endmodule // vri_periph_model

//--- tb/tb_top.sv
`timescale 1ns/1ns
`include "vri_cfg.svh"
module tb_top;
    typedef struct {logic [31:1] act; logic [3:0] thr; logic [4:0] i0; logic [4:0] i1;} vri_row_type;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] irq_target;
    logic [31:1] act = 31'h0, irq_req;
    logic [3:0] prio [1:7] = '{4'h3, 4'h5, 4'h5, 4'h0, 4'h0, 4'hf, 4'h2};
    int num_errors = 0, n_compared = 0;
    // Target 1 threshold stays at 4
    vri_row_type rows [8] = '{
        '{31'h0, 4'h0, 5'h00, 5'h00},
        '{31'h1, 4'h0, 5'h01, 5'h00},
        '{31'h1, 4'h3, 5'h00, 5'h00},
        '{31'h6, 4'h0, 5'h02, 5'h02},
        '{31'h18, 4'h0, 5'h00, 5'h00},
        '{31'h23, 4'he, 5'h06, 5'h06},
        '{31'h41, 4'h2, 5'h01, 5'h00},
        '{31'h4000_0000, 4'h0, 5'h00, 5'h00}};

    always #20 clk_sys = ~clk_sys;

    vri_top uut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_req(irq_req), .irq_target(irq_target), .irq(irq));
    vri_periph_model peri (.line_active(act), .irq_req(irq_req));

    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            num_errors++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask

    initial begin
        int n;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(`VRI_OFS_FEAT, 32'h0001_0f1f, "features");
        rdchk(`VRI_OFS_VEC0, 32'h0, "vector reset");
        wr(`VRI_OFS_FEAT, 32'h0);
        wr(`VRI_OFS_PEND, 32'hffff_ffff);
        rdchk(`VRI_OFS_FEAT, 32'h0001_0f1f, "features ro");
        rdchk(`VRI_OFS_PEND, 32'h0, "pending ro");
        rdchk(12'hff0, 32'h0, "unmapped data");
        chk("unmapped err", {31'h0, er}, 32'h1);
        for (n = 1; n < 8; n++) begin
            wr(12'h404 + 12'(4 * (n - 1)), {28'h0, prio[n]});
        end
        rdchk(12'h418, 32'h0000_000f, "line6 prio");
        wr(`VRI_OFS_VEC0, 32'hffff_ffff);
        wr(`VRI_OFS_VEC1, 32'h1234_5fff);
        wr(`VRI_OFS_THR1, 32'h4);
        foreach (rows[i]) begin
            wr(`VRI_OFS_THR0, {28'h0, rows[i].thr});
            act <= rows[i].act;
            repeat (3) @(posedge clk_sys);
            rdchk(`VRI_OFS_VEC0, {21'h1f_ffff, 3'h0, rows[i].i0, 3'h0}, "vec0");
            rdchk(`VRI_OFS_VEC1, {21'h2_468b, 3'h0, rows[i].i1, 3'h0}, "vec1");
            rdchk(`VRI_OFS_PEND, {rows[i].act, 1'b0}, "pending");
            chk("targets", {30'h0, irq_target}, {30'h0, rows[i].i1 != 5'h00, rows[i].i0 != 5'h00});
        end
        // Interrupt raise, mask, clear
        act <= 31'h0;
        wr(`VRI_OFS_CLR, 32'hffff_fffe);
        wr(`VRI_OFS_EN, 32'h40);
        act <= 31'h20;
        repeat (4) @(posedge clk_sys);
        chk("irq set", {31'h0, irq}, 32'h1);
        rdchk(`VRI_OFS_STAT, 32'h40, "status");
        act <= 31'h0;
        wr(`VRI_OFS_EN, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdchk(`VRI_OFS_STAT, 32'h40, "status sticky");
        wr(`VRI_OFS_CLR, 32'h40);
        wr(`VRI_OFS_EN, 32'h40);
        repeat (2) @(posedge clk_sys);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rdchk(`VRI_OFS_STAT, 32'h0, "status clear");
        // Second reset in mid-run
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(`VRI_OFS_VEC1, 32'h0, "vec1 reset");
        rdchk(`VRI_OFS_THR1, 32'h0, "thr1 reset");
        final_report();
    end
endmodule // tb_top
